//--- src/write_flag_device.sv
// device end: full flag and almost-full status bus of the write port
// Behaviour
// - full flag shows new queue third cycle
// - writer writes only when flag high
// - only selected device drives full flag
// - flag drive starts next cycle after selection
// - full flag changes only on clock
// - mode input sampled at first edge after reset release: polled/direct
// - writer holds mode input steady always
// - direct mode strobe loads addressed status word
// - strobe held low in polled mode
// - no strobe before programming done
// - polled mode cycles four words, one per edge
// - sync high while word one shown
// - token pulses with fourth word; next follows
// - single device: token looped or tied low
`timescale 1ns/1ps
`default_nettype none
module write_flag_device (
    // clock, reset, enable
    input wire logic clk,
    input wire logic resetn,
    input wire logic clk_en,
    // pins toward the write controller
    wflag_if.device link,
    // queue core status and straps
    input wire logic [wflag_pkg::DEV_W-1:0] device_id,
    input wire logic [wflag_pkg::QUEUES-1:0] queue_full,
    input wire logic [wflag_pkg::QUEUES-1:0] queue_almost_full,
    input wire logic programming_done,
    // observation
    output logic polled_mode,
    output logic [wflag_pkg::QSEL_W-1:0] active_queue
);
    typedef enum logic [1:0] {
        ST_CONFIG,
        ST_DIRECT,
        ST_POLL_WAIT,
        ST_POLL_SCAN
    } bus_state_t;

    // true when an address on the bus names this device
    function automatic logic addr_hits(input logic [wflag_pkg::ADDR_W-1:0] addr,
                                       input logic [wflag_pkg::DEV_W-1:0] id);
        addr_hits = addr[wflag_pkg::DEV_LSB +: wflag_pkg::DEV_W] == id;
    endfunction

    bus_state_t state_r, state_nxt;
    logic polled_r, polled_nxt;
    logic [wflag_pkg::DEV_W-1:0] dev_id_r, dev_id_nxt;
    logic owner_r, owner_nxt;
    logic [wflag_pkg::QSEL_W-1:0] qsel_r, qsel_nxt;
    logic [wflag_pkg::QSEL_W-1:0] qstage_r, qstage_nxt;
    logic ready_r, ready_nxt;
    logic present_r, present_nxt;
    logic [wflag_pkg::WIDX_W-1:0] widx_r, widx_nxt;
    logic [wflag_pkg::WORD_W-1:0] word_r, word_nxt;
    logic sync_r, sync_nxt;
    logic token_r, token_nxt;
    logic serial_enable_out_r, serial_enable_out_nxt;
    logic [wflag_pkg::WIDX_W-1:0] pick_idx;
    logic [wflag_pkg::WORD_W-1:0] pick_word;
    logic sel_hit;
    logic strobe_hit;

    // one word selector shared by the direct and the polled paths
    af_word_select u_word (
        .almost_full(queue_almost_full),
        .idx(pick_idx),
        .word(pick_word)
    );

    assign sel_hit = link.write_address_enable && addr_hits(link.write_queue_address, dev_id_r);
    assign strobe_hit = link.almost_full_bus_strobe && addr_hits(link.write_queue_address, dev_id_r);

    // index of the word loaded at this edge
    always_comb
    begin
        if (state_r == ST_DIRECT)
        begin
            pick_idx = link.write_queue_address[wflag_pkg::WIDX_LSB +: wflag_pkg::WIDX_W];
        end
        else if (state_r == ST_POLL_SCAN)
        begin
            pick_idx = widx_r;
        end
        else
        begin
            pick_idx = wflag_pkg::FIRST_WORD;
        end
    end

    // write-queue selection and full flag pipeline
    always_comb
    begin
        owner_nxt = owner_r;
        qsel_nxt = qsel_r;
        if (link.write_address_enable)
        begin
            // any selection moves ownership; losers release the line next cycle
            owner_nxt = sel_hit;
            if (sel_hit)
            begin
                qsel_nxt = link.write_queue_address[wflag_pkg::QSEL_LSB +: wflag_pkg::QSEL_W];
            end
        end
        // extra stage so the new queue shows from the third cycle on
        qstage_nxt = qsel_r;
        // flag high means room; updated only at the clock edge
        ready_nxt = ~queue_full[qstage_r];
    end

    // flag-bus mode, chain position and status word sequencing
    always_comb
    begin
        state_nxt = state_r;
        polled_nxt = polled_r;
        dev_id_nxt = dev_id_r;
        present_nxt = present_r;
        widx_nxt = widx_r;
        word_nxt = word_r;
        sync_nxt = 1'b0;
        token_nxt = 1'b0;
        serial_enable_out_nxt = ~programming_done;
        case (state_r)
            ST_CONFIG:
            begin
                // straps caught at the first edge after reset release
                polled_nxt = link.flag_bus_mode_select;
                dev_id_nxt = device_id;
                widx_nxt = wflag_pkg::FIRST_WORD;
                if (!link.flag_bus_mode_select)
                begin
                    state_nxt = ST_DIRECT;
                end
                else if (device_id == wflag_pkg::CHAIN_HEAD)
                begin
                    // head of the chain starts the scan without a token
                    state_nxt = ST_POLL_SCAN;
                end
                else
                begin
                    state_nxt = ST_POLL_WAIT;
                end
            end
            ST_DIRECT:
            begin
                if (link.almost_full_bus_strobe)
                begin
                    // a strobe for another device releases our bus
                    present_nxt = strobe_hit;
                    if (strobe_hit)
                    begin
                        word_nxt = pick_word;
                    end
                end
            end
            ST_POLL_WAIT:
            begin
                if (link.almost_full_token_in)
                begin
                    // token seen: word one goes out on this edge
                    word_nxt = pick_word;
                    sync_nxt = 1'b1;
                    present_nxt = 1'b1;
                    widx_nxt = wflag_pkg::FIRST_WORD + 2'h1;
                    state_nxt = ST_POLL_SCAN;
                end
                else
                begin
                    present_nxt = 1'b0;
                end
            end
            ST_POLL_SCAN:
            begin
                word_nxt = pick_word;
                present_nxt = 1'b1;
                sync_nxt = widx_r == wflag_pkg::FIRST_WORD;
                token_nxt = widx_r == wflag_pkg::LAST_WORD;
                widx_nxt = widx_r + 2'h1;
                if (widx_r == wflag_pkg::LAST_WORD)
                begin
                    // hand the bus on; a looped token brings us straight back
                    state_nxt = ST_POLL_WAIT;
                    widx_nxt = wflag_pkg::FIRST_WORD;
                end
            end
            default:
            begin
                state_nxt = ST_CONFIG;
            end
        endcase
    end

    // registers; clk_en low freezes everything
    always_ff @(posedge clk or negedge resetn)
    begin
        if (!resetn)
        begin
            state_r <= ST_CONFIG;
            polled_r <= 1'b0;
            dev_id_r <= '0;
            owner_r <= 1'b0;
            qsel_r <= '0;
            qstage_r <= '0;
            ready_r <= 1'b1;
            present_r <= 1'b0;
            widx_r <= wflag_pkg::FIRST_WORD;
            word_r <= wflag_pkg::BUS_IDLE;
            sync_r <= 1'b0;
            token_r <= 1'b0;
            serial_enable_out_r <= 1'b1;
        end
        else if (clk_en)
        begin
            state_r <= state_nxt;
            polled_r <= polled_nxt;
            dev_id_r <= dev_id_nxt;
            owner_r <= owner_nxt;
            qsel_r <= qsel_nxt;
            qstage_r <= qstage_nxt;
            ready_r <= ready_nxt;
            present_r <= present_nxt;
            widx_r <= widx_nxt;
            word_r <= word_nxt;
            sync_r <= sync_nxt;
            token_r <= token_nxt;
            serial_enable_out_r <= serial_enable_out_nxt;
        end
    end

    // pins, all straight from flops
    assign link.input_ready_drv = ready_r;
    assign link.input_ready_oe = owner_r;
    assign link.almost_full_drv = word_r;
    assign link.almost_full_oe = present_r;
    assign link.almost_full_bus_sync = sync_r;
    assign link.almost_full_token_out = token_r;
    assign link.serial_enable_out = serial_enable_out_r;
    assign polled_mode = polled_r;
    assign active_queue = qsel_r;
endmodule
`default_nettype wire

//--- src/wflag_pkg.sv
// shared constants for the write-port flag and almost-full status bus
`default_nettype none
package wflag_pkg;
    localparam int QUEUES = 32;
    localparam int WORD_W = 8;
    localparam int WORDS = 4;
    localparam int ADDR_W = 8;
    localparam int DEV_W = 3;
    localparam int QSEL_W = 5;
    localparam int WIDX_W = 2;
    // address layout: device id on top, queue or status word below
    localparam int DEV_LSB = 5;
    localparam int QSEL_LSB = 0;
    localparam int WIDX_LSB = 0;
    localparam logic [WIDX_W-1:0] FIRST_WORD = 2'h0;
    localparam logic [WIDX_W-1:0] LAST_WORD = 2'h3;
    localparam logic [DEV_W-1:0] CHAIN_HEAD = 3'h0;
    // full flag shows the new queue from the third cycle after selection
    localparam logic [1:0] FLAG_SETTLE = 2'h3;
    localparam logic [1:0] SETTLE_START = 2'h1;
    localparam logic [WORD_W-1:0] BUS_IDLE = 8'hff;
    localparam logic [ADDR_W-1:0] ADDR_RST = 8'h00;
endpackage
`default_nettype wire

//--- src/wflag_if.sv
// write-port flag pins between the queue device and the write controller
`timescale 1ns/1ps
`default_nettype none
interface wflag_if;
    // write-side selection and strobe, from the controller
    logic [wflag_pkg::ADDR_W-1:0] write_queue_address;
    logic write_address_enable;
    logic almost_full_bus_strobe;
    logic flag_bus_mode_select;
    logic almost_full_token_in;
    // device drives, each tri-statable pin split into value and enable
    logic input_ready_drv;
    logic input_ready_oe;
    logic [wflag_pkg::WORD_W-1:0] almost_full_drv;
    logic almost_full_oe;
    logic almost_full_bus_sync;
    logic almost_full_token_out;
    logic serial_enable_out;
    // resolved lines; undriven lines float high through pull-ups
    logic queue_full_flag;
    logic [wflag_pkg::WORD_W-1:0] almost_full_status_bus;
    assign queue_full_flag = input_ready_oe ? input_ready_drv : 1'b1;
    assign almost_full_status_bus = almost_full_oe ? almost_full_drv : wflag_pkg::BUS_IDLE;

    modport device (
        input write_queue_address, write_address_enable, almost_full_bus_strobe,
        input flag_bus_mode_select, almost_full_token_in,
        output input_ready_drv, input_ready_oe, almost_full_drv, almost_full_oe,
        output almost_full_bus_sync, almost_full_token_out, serial_enable_out
    );
    modport host (
        output write_queue_address, write_address_enable, almost_full_bus_strobe,
        output flag_bus_mode_select, almost_full_token_in,
        input queue_full_flag, almost_full_status_bus, almost_full_bus_sync,
        input almost_full_token_out, serial_enable_out
    );
endinterface
`default_nettype wire

//--- src/af_word_select.sv
// picks one eight-queue almost-full status word, active low
`timescale 1ns/1ps
`default_nettype none
module af_word_select (
    // per-queue almost-full, active high
    input wire logic [wflag_pkg::QUEUES-1:0] almost_full,
    // word index
    input wire logic [wflag_pkg::WIDX_W-1:0] idx,
    // status word, one low bit per almost-full queue
    output logic [wflag_pkg::WORD_W-1:0] word
);
    // bit b of word w is queue w*8+b
    genvar b;
    generate
        for (b = 0; b < wflag_pkg::WORD_W; b++)
        begin : g_bit
            assign word[b] = ~almost_full[{idx, 3'(b)}];
        end
    endgenerate
endmodule
`default_nettype wire

//--- src/write_flag_host.sv
// write controller end: queue selection, write permission, status capture
`timescale 1ns/1ps
`default_nettype none
module write_flag_host #(
    parameter bit POLLED = 1'b0
) (
    // clock, reset, enable
    input wire logic clk,
    input wire logic resetn,
    input wire logic clk_en,
    // pins toward the device
    wflag_if.host link,
    // queue selection requests
    input wire logic sel_valid,
    input wire logic [wflag_pkg::ADDR_W-1:0] sel_addr,
    output logic sel_ready,
    // write permission
    output logic flag_settled,
    output logic write_ok,
    // direct-mode status requests
    input wire logic stat_req,
    input wire logic [wflag_pkg::ADDR_W-1:0] stat_addr,
    output logic stat_ready,
    // captured status bus
    output logic [wflag_pkg::WORD_W-1:0] status_word,
    output logic status_sync,
    output logic status_valid
);
    logic write_address_enable_r, write_address_enable_nxt;
    logic strobe_r, strobe_nxt;
    logic [wflag_pkg::ADDR_W-1:0] addr_r, addr_nxt;
    logic [1:0] settle_r, settle_nxt;
    logic [wflag_pkg::WORD_W-1:0] word_r, word_nxt;
    logic sync_r, sync_nxt;
    logic valid_r, valid_nxt;
    logic stb_seen_r, stb_seen_nxt;

    // mode pin is a constant, so it stays steady through reset and after
    assign link.flag_bus_mode_select = POLLED;
    // single device: token looped in polled mode, tied low in direct
    assign link.almost_full_token_in = POLLED ? link.almost_full_token_out : 1'b0;

    // selection wins over a status strobe on the shared address bus
    assign sel_ready = 1'b1;
    assign stat_ready = !POLLED && !link.serial_enable_out && !sel_valid;
    assign flag_settled = settle_r == wflag_pkg::FLAG_SETTLE;
    assign write_ok = flag_settled && !write_address_enable_r && link.queue_full_flag;

    always_comb
    begin
        write_address_enable_nxt = sel_valid;
        strobe_nxt = stat_req && stat_ready;
        addr_nxt = addr_r;
        if (sel_valid)
        begin
            addr_nxt = sel_addr;
        end
        else if (strobe_nxt)
        begin
            addr_nxt = stat_addr;
        end
        // count edges since the selection was taken
        settle_nxt = settle_r;
        if (write_address_enable_r)
        begin
            settle_nxt = wflag_pkg::SETTLE_START;
        end
        else if (settle_r != wflag_pkg::FLAG_SETTLE)
        begin
            settle_nxt = settle_r + 2'h1;
        end
        // sample the bus one cycle after the loading edge
        word_nxt = link.almost_full_status_bus;
        sync_nxt = link.almost_full_bus_sync;
        // strobe delayed to the edge that captures the freshly loaded word
        stb_seen_nxt = strobe_r;
        valid_nxt = POLLED ? 1'b1 : stb_seen_r;
    end

    always_ff @(posedge clk or negedge resetn)
    begin
        if (!resetn)
        begin
            write_address_enable_r <= 1'b0;
            strobe_r <= 1'b0;
            addr_r <= wflag_pkg::ADDR_RST;
            settle_r <= '0;
            word_r <= wflag_pkg::BUS_IDLE;
            sync_r <= 1'b0;
            valid_r <= 1'b0;
            stb_seen_r <= 1'b0;
        end
        else if (clk_en)
        begin
            write_address_enable_r <= write_address_enable_nxt;
            strobe_r <= strobe_nxt;
            addr_r <= addr_nxt;
            settle_r <= settle_nxt;
            word_r <= word_nxt;
            sync_r <= sync_nxt;
            valid_r <= valid_nxt;
            stb_seen_r <= stb_seen_nxt;
        end
    end

    assign link.write_address_enable = write_address_enable_r;
    assign link.almost_full_bus_strobe = strobe_r;
    assign link.write_queue_address = addr_r;
    assign status_word = word_r;
    assign status_sync = sync_r;
    assign status_valid = valid_r;
endmodule
`default_nettype wire

//--- test/wflag_props.sv
// assertions on the write-port flag pins of the direct-mode pair
`timescale 1ns/1ps
`default_nettype none
module wflag_props #(
    parameter logic [2:0] OWN_ID = 3'h0
) (
    // clock and reset
    input wire logic clk,
    input wire logic resetn,
    // controller side
    input wire logic [wflag_pkg::ADDR_W-1:0] write_queue_address,
    input wire logic write_address_enable,
    input wire logic almost_full_bus_strobe,
    input wire logic flag_bus_mode_select,
    // device side
    input wire logic input_ready_oe,
    input wire logic [wflag_pkg::WORD_W-1:0] almost_full_drv,
    input wire logic almost_full_bus_sync,
    input wire logic almost_full_oe,
    input wire logic almost_full_token_out,
    input wire logic serial_enable_out
);
    default clocking @(posedge clk); endclocking
    default disable iff (!resetn);
    // address names this device
    logic own_hit;
    assign own_hit = write_queue_address[wflag_pkg::DEV_LSB +: wflag_pkg::DEV_W] == OWN_ID;
    // selection steps
    sequence own_take;
        write_address_enable && own_hit;
    endsequence
    sequence quiet_two;
        (!write_address_enable) [*2];
    endsequence
    a_sel_drive: assert property (own_take |=> input_ready_oe)
        else $error("flag not driven after own selection");
    a_other_release: assert property (write_address_enable && !own_hit |=> !input_ready_oe)
        else $error("flag still driven after foreign selection");
    a_owner_hold: assert property (own_take ##1 quiet_two |-> input_ready_oe)
        else $error("flag drive lost while settling");
    a_oe_steady: assert property (!write_address_enable |=> $stable(input_ready_oe))
        else $error("flag drive changed without selection");
    a_strobe_answer: assert property (almost_full_bus_strobe && !flag_bus_mode_select && own_hit
        |=> almost_full_oe)
        else $error("status bus not driven after strobe");
    a_word_holds: assert property (!almost_full_bus_strobe && !flag_bus_mode_select
        |=> $stable(almost_full_drv))
        else $error("status word changed without strobe");
    a_sync_quiet: assert property (!flag_bus_mode_select |-> !almost_full_bus_sync)
        else $error("sync high in direct mode");
    a_token_quiet: assert property (!flag_bus_mode_select |-> !almost_full_token_out)
        else $error("token high in direct mode");
    a_strobe_ready: assert property (almost_full_bus_strobe |-> !serial_enable_out)
        else $error("strobe before programming done");
endmodule
`default_nettype wire

//--- test/tb.sv
// self-checking bench: direct and polled flag pairs driven from their user sides
`timescale 1ns/1ps
`default_nettype none
module tb;
    localparam logic [2:0] DEV_D = 3'h2;
    logic clk = 1'b0;
    logic resetn = 1'b0;
    logic en = 1'b1;
    logic [31:0] q_full = 32'h0000_0020;
    logic [31:0] q_af = 32'h8142_0c03;
    logic prog_done = 1'b0;
    logic sel_valid = 1'b0;
    logic [7:0] sel_addr = 8'h00;
    logic stat_req = 1'b0;
    logic [7:0] stat_addr = 8'h00;
    logic settled, wr_ok, st_ready, st_valid, pm_d, pm_p, prev, prev_own, p_sync, p_valid;
    logic [7:0] st_word, p_word;
    int error_cnt = 0;
    int n_checks = 0;
    int cycles = 0;
    wflag_if if_d();
    wflag_if if_p();
    // direct pair with checker, polled pair as a looped single device
    write_flag_device write_flag_device_inst (.clk(clk), .resetn(resetn), .clk_en(en), .link(if_d),
        .device_id(DEV_D), .queue_full(q_full), .queue_almost_full(q_af), .programming_done(prog_done),
        .polled_mode(pm_d), .active_queue());
    write_flag_host #(.POLLED(1'b0)) write_flag_host_inst (.clk(clk), .resetn(resetn), .clk_en(en),
        .link(if_d), .sel_valid(sel_valid), .sel_addr(sel_addr), .sel_ready(), .flag_settled(settled),
        .write_ok(wr_ok), .stat_req(stat_req), .stat_addr(stat_addr), .stat_ready(st_ready),
        .status_word(st_word), .status_sync(), .status_valid(st_valid));
    write_flag_device write_flag_device_inst_p (.clk(clk), .resetn(resetn), .clk_en(en), .link(if_p),
        .device_id(3'h0), .queue_full(q_full), .queue_almost_full(q_af), .programming_done(prog_done),
        .polled_mode(pm_p), .active_queue());
    write_flag_host #(.POLLED(1'b1)) write_flag_host_inst_p (.clk(clk), .resetn(resetn), .clk_en(en),
        .link(if_p), .sel_valid(sel_valid), .sel_addr(sel_addr), .sel_ready(), .flag_settled(),
        .write_ok(), .stat_req(1'b0), .stat_addr(8'h00), .stat_ready(), .status_word(p_word),
        .status_sync(p_sync), .status_valid(p_valid));
    wflag_props #(.OWN_ID(DEV_D)) wflag_props_inst (.clk(clk), .resetn(resetn),
        .write_queue_address(if_d.write_queue_address), .write_address_enable(if_d.write_address_enable),
        .almost_full_bus_strobe(if_d.almost_full_bus_strobe), .flag_bus_mode_select(if_d.flag_bus_mode_select),
        .input_ready_oe(if_d.input_ready_oe), .almost_full_drv(if_d.almost_full_drv),
        .almost_full_bus_sync(if_d.almost_full_bus_sync), .almost_full_oe(if_d.almost_full_oe),
        .almost_full_token_out(if_d.almost_full_token_out), .serial_enable_out(if_d.serial_enable_out));

    always #4 clk = ~clk;

    // hang guard, far above the fewer than a hundred cycles the tests need
    always @(posedge clk)
    begin
        cycles++;
        if (cycles == 3000)
        begin
            error_cnt++;
            print_verdict();
        end
    end

    task automatic print_verdict();
        $display("checks %0d mismatches %0d", n_checks, error_cnt);
        if (error_cnt == 0 && n_checks > 0)
            $display("All checks passed");
        else
            $display("Checks failed");
        $finish;
    endtask

    task automatic chk(input logic [7:0] got, input logic [7:0] exp, input string what);
        n_checks++;
        if (got !== exp)
        begin
            error_cnt++;
            $display("[ERR] %0t %s: got %h want %h", $time, what, got, exp);
        end
    endtask

    // one-cycle selection request; drive, stale flag (own after own only) and new flag checked in turn until settled
    task automatic select_queue(input logic [2:0] dev, input logic [4:0] q, input logic own, input logic exp);
        sel_addr = {dev, q};
        sel_valid = 1'b1;
        @(negedge clk);
        sel_valid = 1'b0;
        @(negedge clk);
        chk({7'h0, if_d.input_ready_oe}, {7'h0, own}, "flag drive");
        @(negedge clk);
        if (own && prev_own)
            chk({7'h0, if_d.queue_full_flag}, {7'h0, prev}, "stale flag");
        @(negedge clk);
        chk({7'h0, if_d.queue_full_flag}, {7'h0, exp}, "new queue flag");
        chk({6'h0, settled, wr_ok}, {6'h0, 1'b1, exp}, "write permission");
        prev = exp;
        prev_own = own;
    endtask

    // direct strobe of one status word, compared on the bus and in the host
    task automatic read_status(input logic [2:0] dev, input logic [1:0] w, input logic [7:0] exp);
        int i;
        stat_addr = {dev, 3'h0, w};
        stat_req = 1'b1;
        @(negedge clk);
        stat_req = 1'b0;
        for (i = 0; i < 8 && st_valid !== 1'b1; i++)
            @(negedge clk);
        chk(st_word, exp, "captured word");
        chk(if_d.almost_full_status_bus, exp, "status bus");
    endtask

    initial
    begin
        int i;
        prev = 1'b1;
        prev_own = 1'b0;
        repeat (8) @(negedge clk);
        chk({5'h0, if_d.queue_full_flag, if_d.serial_enable_out, if_d.almost_full_bus_sync}, 8'h06, "reset pins");
        chk(if_d.almost_full_status_bus, 8'hff, "reset bus");
        resetn = 1'b1;
        repeat (3) @(negedge clk);
        chk({6'h0, pm_d, pm_p}, 8'h01, "mode capture");
        chk({7'h0, st_ready}, 8'h00, "strobe before programming");
        prog_done = 1'b1;
        repeat (2) @(negedge clk);
        chk({7'h0, st_ready}, 8'h01, "strobe after programming");
        $display("test reset done");
        // own queues, full and not full, then foreign device, then back
        select_queue(DEV_D, 5'h03, 1'b1, 1'b1);
        select_queue(DEV_D, 5'h05, 1'b1, 1'b0);
        select_queue(DEV_D, 5'h03, 1'b1, 1'b1);
        select_queue(3'h5, 5'h03, 1'b0, 1'b1);
        select_queue(DEV_D, 5'h05, 1'b1, 1'b0);
        // flag moves only at the next clock edge
        q_full[5] = 1'b0;
        #1 chk({7'h0, if_d.queue_full_flag}, 8'h00, "flag between edges");
        @(negedge clk);
        chk({7'h0, if_d.queue_full_flag}, 8'h01, "flag after edge");
        $display("test selection done");
        for (i = 0; i < 4; i++)
            read_status(DEV_D, i[1:0], ~q_af[8*i +: 8]);
        // a strobe naming another device releases this device's bus
        read_status(3'h5, 2'h1, 8'hff);
        $display("test direct status done");
        // polled pair: token looped back by the host keeps a four-word rotation
        for (i = 0; i < 8 && if_p.almost_full_bus_sync !== 1'b1; i++)
            @(negedge clk);
        for (i = 0; i < 8; i++)
        begin
            chk(if_p.almost_full_status_bus, ~q_af[8*(i%4) +: 8], "polled word");
            chk({5'h0, if_p.almost_full_bus_sync, if_p.almost_full_token_out, if_p.almost_full_bus_strobe},
                {5'h0, i % 4 == 0, i % 4 == 3, 1'b0}, "sync and token");
            // host captures each bus word one edge after it is loaded
            chk(p_word, ~q_af[8*((i+3)%4) +: 8], "host polled word");
            chk({6'h0, p_valid, p_sync}, {6'h0, 1'b1, i % 4 == 1}, "host polled sync");
            @(negedge clk);
        end
        $display("test polled rotation done");
        print_verdict();
    end
endmodule
`default_nettype wire
